// *** src/csc_supervisor.v ***
// Operation
// RULE_01: A run starts only after enable is set; interval chosen by select.
// RULE_02: Count external edges only between two time-base rising edges.
// RULE_03: Software picks main or sub oscillator as counted source.
// RULE_04: Result clears to zero when enable goes from 0 to 1.
// RULE_05: Counter saturates at 255 and never wraps.
// RULE_06: A stopped external clock leaves the count unchanged.
// RULE_07: Clearing enable mid-run aborts and clears counter to 0.
// RULE_08: Final count is readable in the result register.
// RULE_09: Control register holds source, interval, start and busy flag.
// RULE_10: Software runs this from main CR with the watchdog active.
// RULE_11: Closing time-base edge stops count, loads result, clears busy.
// RULE_12: Result is 8-bit read-only, reset 0, holds last count.
// RULE_13: Interval codes 0..7 give 2^3..2^17 main CR periods.
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "csc_defines.vh"
module csc_supervisor (
	input wire core_clk,
	input wire resetn,
	input wire main_osc_clk,
	input wire sub_osc_clk,
	input wire cr_clk,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	output wire irq
);
	localparam ST_IDLE = 3'b001;
	localparam ST_ARM = 3'b010;
	localparam ST_COUNT = 3'b100;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [2:0] gate_interval_select;
	reg src_sub;
	reg monitor_enable;
	reg [7:0] count_result_register;
	reg [1:0] irq_stat;
	reg [1:0] irq_en;
	reg wr_pend;
	reg [7:0] wr_addr;
	reg sat_d;
	wire tb_rise;
	wire [7:0] count;
	wire saturated;
	wire busy;
	wire wr_ctrl;
	wire en_rise;
	wire en_fall;
	wire finish;
	wire [1:0] events;
	wire [1:0] clr_bits;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign busy = (state != ST_IDLE);
	assign wr_ctrl = wr_pend && (wr_addr == `CSC_CTRL_OFF);
	assign en_rise = wr_ctrl && hwdata[`CSC_EN_BIT] && !monitor_enable;
	assign en_fall = wr_ctrl && !hwdata[`CSC_EN_BIT] && monitor_enable;
	assign finish = (state == ST_COUNT) && tb_rise && !en_fall;
	assign clr_bits = (wr_pend && wr_addr == `CSC_IRQ_CLR_OFF) ?
		hwdata[1:0] : 2'b00;
	assign events = {saturated & ~sat_d & busy, finish};
	assign irq = |(irq_stat & irq_en);

	csc_timebase u_tb (
		.core_clk(core_clk),
		.resetn(resetn),
		.cr_clk(cr_clk),
		.gate_interval_select(gate_interval_select),
		.tb_rise(tb_rise)
	);

	csc_counter u_cnt (
		.core_clk(core_clk),
		.resetn(resetn),
		.main_osc_clk(main_osc_clk),
		.sub_osc_clk(sub_osc_clk),
		.src_sub(src_sub),
		.count_en(state == ST_COUNT), // RULE_02
		.clear(en_rise || en_fall), // RULE_07
		.count(count),
		.saturated(saturated)
	);

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (en_rise)
					next_state = ST_ARM; // RULE_01
			end
			ST_ARM: begin
				// Wait for opening edge of the gate window
				if (en_fall)
					next_state = ST_IDLE;
				else if (tb_rise)
					next_state = ST_COUNT; // RULE_02
			end
			ST_COUNT: begin
				if (en_fall)
					next_state = ST_IDLE; // RULE_07
				else if (tb_rise)
					next_state = ST_IDLE; // RULE_11
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			gate_interval_select <= 3'h0;
			src_sub <= 1'b0;
			monitor_enable <= 1'b0;
			count_result_register <= `CSC_RESULT_RST; // RULE_12
			irq_stat <= 2'b00;
			irq_en <= 2'b00;
			sat_d <= 1'b0;
		end else begin
			state <= next_state;
			sat_d <= saturated;
			wr_pend <= hsel && hready && htrans[1] && hwrite;
			if (hsel && hready && htrans[1])
				wr_addr <= haddr;
			if (wr_ctrl) begin
				gate_interval_select <=
					hwdata[`CSC_SEL_HI:`CSC_SEL_LO]; // RULE_09
				src_sub <= hwdata[`CSC_SRC_BIT];
				// A run ending in this cycle still self-clears
				monitor_enable <= hwdata[`CSC_EN_BIT] && !finish;
			end else if (finish)
				monitor_enable <= 1'b0;
			if (en_rise)
				count_result_register <= 8'h00; // RULE_04
			else if (finish)
				count_result_register <= count; // RULE_08
			if (wr_pend && wr_addr == `CSC_IRQ_EN_OFF)
				irq_en <= hwdata[1:0];
			// Set wins over a simultaneous clear
			irq_stat <= (irq_stat & ~clr_bits) | events;
		end
	end

	// Read data registered in the data phase cycle
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			hrdata <= 32'h00000000;
		else if (hsel && hready && htrans[1] && !hwrite) begin
			case (haddr)
				`CSC_CTRL_OFF: hrdata <= {24'h000000, monitor_enable,
					busy, 1'b0, src_sub, 1'b0,
					gate_interval_select}; // RULE_09
				`CSC_RESULT_OFF: hrdata <= {24'h000000,
					count_result_register}; // RULE_12
				`CSC_IRQ_STAT_OFF: hrdata <= {30'h00000000, irq_stat};
				`CSC_IRQ_EN_OFF: hrdata <= {30'h00000000, irq_en};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end
endmodule // csc_supervisor

// *** src/csc_defines.vh ***
`ifndef CSC_DEFINES_VH
`define CSC_DEFINES_VH
// Register byte offsets
`define CSC_CTRL_OFF 8'h00
`define CSC_RESULT_OFF 8'h04
`define CSC_IRQ_STAT_OFF 8'h08
`define CSC_IRQ_EN_OFF 8'h0c
`define CSC_IRQ_CLR_OFF 8'h10
// Control register fields
`define CSC_SEL_LO 0
`define CSC_SEL_HI 2
`define CSC_SRC_BIT 4
`define CSC_RUN_BIT 6
`define CSC_EN_BIT 7
// Reset values
`define CSC_CTRL_RST 8'h00
`define CSC_RESULT_RST 8'h00
// Counter limits
`define CSC_CNT_MAX 8'hff
// Gate interval: 2^(3+2*sel) main CR periods
`define CSC_TB_BASE_EXP 3
`define CSC_TB_STEP_EXP 2
`define CSC_TB_WIDTH 18
// Interrupt events
`define CSC_EV_DONE 0
`define CSC_EV_SAT 1
`endif

// *** src/csc_timebase.v ***
`timescale 1ns/1ps
`include "csc_defines.vh"
// Free-running time base on the main CR clock; rising-edge pulse of tap.
module csc_timebase (
	input wire core_clk,
	input wire resetn,
	input wire cr_clk,
	input wire [2:0] gate_interval_select,
	output reg tb_rise
);
	reg [`CSC_TB_WIDTH-1:0] tb_cnt;
	reg [`CSC_TB_WIDTH-1:0] tb_prev;
	reg cr_d;
	wire cr_rise;
	wire [4:0] tap_sel;
	function [4:0] tap_index;
		input [2:0] sel;
		integer idx;
		begin
			// Bit n toggles with period 2^(n+1) periods
			idx = `CSC_TB_BASE_EXP - 1 + `CSC_TB_STEP_EXP * sel;
			tap_index = idx[4:0];
		end
	endfunction
	assign cr_rise = cr_clk & ~cr_d;
	assign tap_sel = tap_index(gate_interval_select);
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tb_cnt <= {`CSC_TB_WIDTH{1'b0}};
			cr_d <= 1'b0;
			tb_prev <= {`CSC_TB_WIDTH{1'b0}};
			tb_rise <= 1'b0;
		end else begin
			cr_d <= cr_clk;
			if (cr_rise)
				tb_cnt <= tb_cnt + 1'b1;
			tb_prev <= tb_cnt;
			// Same tap on both samples: a select change makes no false edge
			tb_rise <= tb_cnt[tap_sel] & ~tb_prev[tap_sel]; // RULE_13
		end
	end
endmodule // csc_timebase

// *** src/csc_counter.v ***
`timescale 1ns/1ps
`include "csc_defines.vh"
// Edge counter of the selected external clock, saturating.
module csc_counter (
	input wire core_clk,
	input wire resetn,
	input wire main_osc_clk,
	input wire sub_osc_clk,
	input wire src_sub,
	input wire count_en,
	input wire clear,
	output reg [7:0] count,
	output wire saturated
);
	reg ext_d;
	wire ext;
	wire ext_rise;
	assign ext = src_sub ? sub_osc_clk : main_osc_clk; // RULE_03
	assign ext_rise = ext & ~ext_d;
	assign saturated = (count == `CSC_CNT_MAX);
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ext_d <= 1'b0;
			count <= 8'h00;
		end else begin
			ext_d <= ext;
			if (clear)
				count <= 8'h00;
			// A stopped clock gives no edges, so the count stays put
			else if (count_en && ext_rise && !saturated) // RULE_06
				count <= count + 8'h01; // RULE_05
		end
	end
endmodule // csc_counter

// *** verification/csc_props.sv ***
`timescale 1ns/1ps
module csc_props (
	input wire core_clk,
	input wire resetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire irq
);
	reg rd_ph;
	reg wr_ph;
	reg [7:0] ph_a;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rd_ph <= 1'b0;
			wr_ph <= 1'b0;
			ph_a <= 8'h00;
		end else begin
			rd_ph <= hsel & hready & htrans[1] & !hwrite;
			wr_ph <= hsel & hready & htrans[1] & hwrite;
			ph_a <= haddr;
		end
	end
	property p_rst; $rose(resetn) |-> hrdata == 0 && !irq; endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	property p_res; rd_ph && ph_a == 8'h04 |-> hrdata[31:8] == 0; endproperty
	a_res: assert property (p_res) else $error("result width");
	property p_ctl; rd_ph && ph_a == 8'h00 |-> hrdata[31:8] == 0
		&& !hrdata[5] && !hrdata[3]; endproperty
	a_ctl: assert property (p_ctl) else $error("ctrl bits");
	property p_unm; rd_ph && ph_a > 8'h13 |-> hrdata == 0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped");
	property p_hold; !rd_ph |-> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("data moved");
	property p_irq; wr_ph && ph_a == 8'h0c && hwdata[1:0] == 0 |=> !irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq unmasked");
	property p_ok; hreadyout && !hresp; endproperty
	a_ok: assert property (p_ok) else $error("bus answer");
	property p_st; rd_ph && ph_a == 8'h08 |-> hrdata[31:2] == 0; endproperty
	a_st: assert property (p_st) else $error("status bits");
endmodule // csc_props
bind csc_supervisor csc_props u_csc_props (.core_clk(core_clk),
	.resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .irq(irq));

// *** verification/csc_osc_model.sv ***
`timescale 1ns/1ps
module csc_osc_model (
	input wire run_osc,
	output reg main_osc_clk,
	output reg sub_osc_clk
);
	integer k = 0;
	initial main_osc_clk = 1'b0;
	initial sub_osc_clk = 1'b0;
	// A dead crystal freezes at its last level
	always #20 if (run_osc) begin
		main_osc_clk = !main_osc_clk;
		k = k + 1;
		if (k % 2) sub_osc_clk = !sub_osc_clk;
	end
endmodule // csc_osc_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	reg core_clk = 1'b0;
	reg resetn = 1'b0;
	reg [1:0] cr_div = 2'b00;
	reg run_osc = 1'b1;
	reg [7:0] haddr = 8'h00;
	reg [1:0] htrans = 2'b00;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	wire main_osc_clk, sub_osc_clk, hreadyout, hresp, irq;
	wire [31:0] hrdata;
	integer n_errors = 0;
	integer num_checks = 0;
	integer i;
	reg [31:0] r, p;
	always #2.5 core_clk = !core_clk;
	always @(posedge core_clk) cr_div <= cr_div + 2'b01;
	csc_osc_model u_csc_osc_model (.run_osc(run_osc),
		.main_osc_clk(main_osc_clk), .sub_osc_clk(sub_osc_clk));
	csc_supervisor u_csc_supervisor (.core_clk(core_clk), .resetn(resetn),
		.main_osc_clk(main_osc_clk), .sub_osc_clk(sub_osc_clk),
		.cr_clk(cr_div[1]), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
	task chk(input [31:0] g, input [31:0] lo, input [31:0] hi);
		begin
			num_checks = num_checks + 1;
			if ((g >= lo && g <= hi) !== 1'b1) begin
				n_errors = n_errors + 1;
				$display("ERROR %0t got %h exp %h-%h", $time, g, lo, hi);
			end
		end
	endtask
	task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
		begin
			haddr <= a;
			hwrite <= w;
			htrans <= 2'b10;
			@(posedge core_clk);
			while (hreadyout !== 1'b1) @(posedge core_clk);
			htrans <= 2'b00;
			hwdata <= d;
			@(posedge core_clk);
			while (hreadyout !== 1'b1) @(posedge core_clk);
			q = hrdata;
		end
	endtask
	task run(input [7:0] c);
		begin
			xfer(1, 8'h00, {24'h0, c}, r);
			xfer(0, 8'h04, 0, r);
			chk(r, 0, 0);
			xfer(0, 8'h00, 0, r);
			chk(r[7:6], 3, 3);
			while (r[6] !== 1'b0) xfer(0, 8'h00, 0, r);
			chk(r, c & 8'h17, c & 8'h17);
			xfer(0, 8'h04, 0, r);
		end
	endtask
	task conclude;
		begin
			if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
			else $display("Run complete: FAIL");
			$finish;
		end
	endtask
	initial begin
		#200000;
		n_errors = n_errors + 1;
		conclude;
	end
	initial begin
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		xfer(0, 8'h04, 0, r);
		chk(r, 0, 0);
		xfer(0, 8'h20, 0, r);
		xfer(1, 8'h0c, 1, r);
		// Codes 4..7 need up to 2^17 periods; too long for this run
		for (i = 0; i < 4; i = i + 1) begin
			run(8'h80 | i[2:0]);
			p = 4 << (2 * i);
			chk(r, p - 1, (i == 3) ? 255 : p + 1);
		end
		// Just after a long window, so the abort below lands mid-count
		xfer(1, 8'h00, 8'h83, r);
		repeat (3000) @(posedge core_clk);
		xfer(1, 8'h00, 0, r);
		xfer(0, 8'h00, 0, r);
		chk(r, 0, 0);
		xfer(0, 8'h04, 0, r);
		chk(r, 0, 0);
		xfer(0, 8'h08, 0, r);
		chk(r, 3, 3);
		chk(irq, 1, 1);
		xfer(1, 8'h10, 3, r);
		@(posedge core_clk);
		chk(irq, 0, 0);
		run(8'h91);
		chk(r, 7, 9);
		p = r;
		xfer(1, 8'h04, 8'h55, r);
		xfer(0, 8'h04, 0, r);
		chk(r, p, p);
		xfer(1, 8'h0c, 0, r);
		run_osc <= 1'b0;
		run(8'h81);
		chk(r, 0, 0);
		xfer(0, 8'h08, 0, r);
		chk({r[0], irq}, 2, 2);
		conclude;
	end
endmodule // tb_top
